// ==== core/tadc_pkg.sv ====
// Package: offsets, fields and types of the timer auxiliary control block
package tadc_pkg;
	// Register byte offsets
	localparam logic [8:0] OFS_CH0CV = 9'h034;
	localparam logic [8:0] OFS_CH3CV = 9'h040;
	localparam logic [8:0] OFS_CTL2 = 9'h074;
	localparam logic [8:0] OFS_AFCTL1 = 9'h090;
	localparam logic [8:0] OFS_PERIOD = 9'h094;
	localparam logic [8:0] OFS_DECCTL = 9'h0A0;
	localparam logic [8:0] OFS_DMCFG = 9'h0E0;
	localparam logic [8:0] OFS_WINDOW = 9'h0E4;
	localparam logic [8:0] OFS_CFG = 9'h0FC;
	// Reset values
	localparam logic [31:0] RST_ZERO = 32'h00000000;
	localparam logic [31:0] RST_PERIOD = 32'hFFFFFFFF;
	// Writable bit masks (reserved bits stay zero)
	localparam logic [31:0] MSK_CTL2 = 32'h000CFF00;
	localparam logic [31:0] MSK_AFCTL1 = 32'h00380000;
	localparam logic [31:0] MSK_DECCTL = 32'h07FF00E7;
	localparam logic [31:0] MSK_DMCFG = 32'h00003F3F;
	localparam logic [31:0] MSK_CFG = 32'h00000002;
	// Field positions
	localparam int POS_JUMP_EN = 18;
	localparam int POS_DISC_EN = 19;
	localparam int POS_MPSEL = 8;
	localparam int POS_CLRSEL = 19;
	localparam int POS_PSC = 24;
	localparam int POS_PWID = 16;
	localparam int POS_IDXPOS = 6;
	localparam int POS_FIRST = 5;
	localparam int POS_IDXDIR = 1;
	localparam int POS_IDXEN = 0;
	localparam int POS_BCOUNT = 8;
	localparam int POS_BSTART = 0;
	localparam int POS_SKIPEQ = 1;
	// Match pulse select codes
	localparam logic [1:0] MP_NORMAL = 2'h0;
	localparam logic [1:0] MP_UP = 2'h1;
	localparam logic [1:0] MP_DOWN = 2'h2;
	// Index reset direction codes
	localparam logic [1:0] DIR_BOTH = 2'h0;
	localparam logic [1:0] DIR_UP = 2'h1;
	localparam logic [1:0] DIR_DOWN = 2'h2;
	// Register access request carried as one bundle
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} tadc_req_t;
	// Pulse generator states
	typedef enum logic {PG_IDLE, PG_RUN} tadc_pg_t;
endpackage : tadc_pkg

// ==== core/tadc_top.sv ====
// Timer auxiliary logic: match pulses, clear select, decoder support, DMA window
`timescale 1ns/1ps
// Notes on behaviour
// R1 - Jump enable flags simultaneous A and B changes
// R2 - Code 00 passes normal compare reference output
// R3 - Code 01 pulses one cycle on up-count match
// R4 - Code 10 pulses one cycle on down-count match
// R5 - Code 11 pulses on match either direction
// R6 - Three-bit selector picks one of eight clears
// R7 - Supervision counters reaching period set disconnect flag
// R8 - Period only counts while disconnect detection enabled
// R9 - Pulse clock period is two to prescale
// R10 - Pulse width is width field times pulse clock
// R11 - Index resets only at matching AB position
// R12 - Clock/direction modes use only low position bit
// R13 - First-only bit lets just first index reset
// R14 - Direction field chooses up, down or both
// R15 - Software changes direction only while index disabled; not enforced, any decctl write updates idx_dir
// R16 - Index resets only while index enable set
// R17 - Burst length is count field plus one
// R18 - Burst starts at base plus four times start
// R19 - Window access redirects to start plus four count
// R20 - Skip bit drops compare writes equal to content
// R21 - Transfer count wraps to zero after burst
module tadc_top #(
	parameter bit HAS_CMP = 1'b1 // Instance with comparator clear sources
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire tadc_pkg::tadc_req_t req_i, // Register access
	output logic [31:0] rdata_o, // Read data, one cycle after request
	output logic rvalid_o, // Read data valid pulse
	output logic [8:0] fwd_addr_o, // Kernel register address
	output logic fwd_wr_o, // Kernel register write strobe
	output logic fwd_rd_o, // Kernel register read strobe
	output logic [31:0] fwd_wdata_o, // Kernel write data
	input wire logic [31:0] fwd_rdata_i, // Kernel read data, same cycle
	input wire logic [3:0][31:0] cmp_val_i, // Current channel compare values
	input wire logic [3:0] match_i, // Channel match events
	input wire logic [3:0] cmp_ref_i, // Normal channel reference levels
	input wire logic count_down_i, // Counter direction, 1 = down
	input wire logic clk_dir_mode_i, // Decoder in clock/direction mode
	input wire logic [7:0] cmp_out_i, // Comparator outputs
	input wire logic enc_a_i, // Quadrature input A
	input wire logic enc_b_i, // Quadrature input B
	input wire logic enc_idx_i, // Index input
	input wire logic disconnect_irq_en_i, // Disconnect interrupt enable
	input wire logic disconnect_clr_i, // Disconnect flag clear pulse
	output logic [3:0] ch_ref_o, // Channel reference outputs
	output logic ref_clear_o, // Selected reference clear
	output logic jump_o, // Jump detected pulse
	output logic disconnect_flag_o, // Sticky disconnect flag
	output logic disconnect_irq_o, // Disconnect interrupt
	output logic cnt_reset_o, // Index counter reset pulse
	output logic dec_pulse_o // Decoder output pulse
);
	// Software registers
	logic [31:0] ctl2, afctl1, period, decctl, dmcfg, cfg;
	logic [5:0] xfer_cnt; // Hardware transfer count in a burst
	// Synchroniser stages for pins and comparators
	logic [10:0] sy1, sy2, sy3, pin, pin_q; // pin_q holds the last value
	// Disconnect supervision counters for A and B
	logic [31:0] sup_a, sup_b;
	logic first_done; // First index already used
	tadc_pkg::tadc_pg_t pg_st;
	logic [6:0] pre_cnt; // Pulse clock prescaler
	logic [7:0] wid_cnt; // Pulse clock ticks elapsed
	// Fields
	logic [1:0] mpsel [4];
	logic [2:0] psc;
	logic [7:0] pwid;
	logic [1:0] idx_pos, idx_dir;
	logic [5:0] bcount, bstart;
	assign psc = decctl[tadc_pkg::POS_PSC +: 3];
	assign pwid = decctl[tadc_pkg::POS_PWID +: 8];
	assign idx_pos = decctl[tadc_pkg::POS_IDXPOS +: 2];
	assign idx_dir = decctl[tadc_pkg::POS_IDXDIR +: 2];
	assign bcount = dmcfg[tadc_pkg::POS_BCOUNT +: 6];
	assign bstart = dmcfg[tadc_pkg::POS_BSTART +: 6];
	// Address redirect: window accesses go to start plus four times count
	logic is_win;
	logic [8:0] eff;
	assign is_win = (req_i.wr | req_i.rd) &&
		({1'b0, req_i.addr} == tadc_pkg::OFS_WINDOW);
	assign eff = is_win ? 9'({bstart, 2'b00}) + 9'({xfer_cnt, 2'b00}) // R18 R19
		: {1'b0, req_i.addr};
	// Own register decode on the effective address
	logic own;
	always_comb begin
		case (eff)
			tadc_pkg::OFS_CTL2, tadc_pkg::OFS_AFCTL1, tadc_pkg::OFS_PERIOD,
			tadc_pkg::OFS_DECCTL, tadc_pkg::OFS_DMCFG, tadc_pkg::OFS_CFG,
			tadc_pkg::OFS_WINDOW: own = 1'b1;
			default: own = 1'b0;
		endcase
	end
	// Equal-write filter on compare registers
	logic is_cv, same;
	logic [1:0] cv_idx;
	assign is_cv = eff >= tadc_pkg::OFS_CH0CV && eff <= tadc_pkg::OFS_CH3CV
		&& eff[1:0] == 2'b00;
	assign cv_idx = 2'(eff[3:2] - tadc_pkg::OFS_CH0CV[3:2]);
	assign same = is_cv && req_i.wdata == cmp_val_i[cv_idx];
	// Kernel forward port; combinational strobes
	assign fwd_addr_o = eff;
	assign fwd_wdata_o = req_i.wdata;
	assign fwd_rd_o = req_i.rd && !own;
	assign fwd_wr_o = req_i.wr && !own &&
		!(cfg[tadc_pkg::POS_SKIPEQ] && same); // R20
	// Software writes to own registers; reserved bits held at zero
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctl2 <= tadc_pkg::RST_ZERO;
			afctl1 <= tadc_pkg::RST_ZERO;
			period <= tadc_pkg::RST_PERIOD; // R7
			decctl <= tadc_pkg::RST_ZERO;
			dmcfg <= tadc_pkg::RST_ZERO;
			cfg <= tadc_pkg::RST_ZERO;
		end else if (req_i.wr) begin
			case (eff)
				tadc_pkg::OFS_CTL2: ctl2 <= req_i.wdata & tadc_pkg::MSK_CTL2;
				tadc_pkg::OFS_AFCTL1:
					afctl1 <= req_i.wdata & tadc_pkg::MSK_AFCTL1;
				tadc_pkg::OFS_PERIOD: period <= req_i.wdata;
				tadc_pkg::OFS_DECCTL:
					decctl <= req_i.wdata & tadc_pkg::MSK_DECCTL;
				tadc_pkg::OFS_DMCFG: dmcfg <= req_i.wdata & tadc_pkg::MSK_DMCFG;
				tadc_pkg::OFS_CFG: cfg <= req_i.wdata & tadc_pkg::MSK_CFG;
				default: ;
			endcase
		end
	end
	// Burst transfer count: steps per window access, wraps after last
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			xfer_cnt <= 6'h00;
		else if (is_win)
			xfer_cnt <= (xfer_cnt >= bcount) ? 6'h00 // R17 R21
				: xfer_cnt + 6'h01;
	end
	// Read data is registered so the bus sees a flip-flop output
	logic [31:0] next_rdata;
	always_comb begin
		case (eff)
			tadc_pkg::OFS_CTL2: next_rdata = ctl2;
			tadc_pkg::OFS_AFCTL1: next_rdata = afctl1;
			tadc_pkg::OFS_PERIOD: next_rdata = period;
			tadc_pkg::OFS_DECCTL: next_rdata = decctl;
			tadc_pkg::OFS_DMCFG: next_rdata = dmcfg;
			tadc_pkg::OFS_CFG: next_rdata = cfg;
			tadc_pkg::OFS_WINDOW: next_rdata = tadc_pkg::RST_ZERO;
			default: next_rdata = fwd_rdata_i;
		endcase
	end
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_o <= tadc_pkg::RST_ZERO;
			rvalid_o <= 1'b0;
		end else begin
			rvalid_o <= req_i.rd;
			if (req_i.rd)
				rdata_o <= next_rdata;
		end
	end

	// Three-stage synchroniser; a change counts once stages 2 and 3 agree
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sy1 <= 11'h000;
			sy2 <= 11'h000;
			sy3 <= 11'h000;
			pin <= 11'h000;
			pin_q <= 11'h000;
		end else begin
			sy1 <= {cmp_out_i, enc_idx_i, enc_b_i, enc_a_i};
			sy2 <= sy1;
			sy3 <= sy2;
			pin_q <= pin;
			for (int i = 0; i < 11; i++)
				if (sy2[i] == sy3[i])
					pin[i] <= sy3[i];
		end
	end
	logic a_chg, b_chg, idx_rise;
	assign a_chg = pin[0] ^ pin_q[0];
	assign b_chg = pin[1] ^ pin_q[1];
	assign idx_rise = pin[2] & ~pin_q[2];

	// Reference clear mux; reserved sources read low on other instances
	assign ref_clear_o = HAS_CMP ?
		pin[3 + afctl1[tadc_pkg::POS_CLRSEL +: 3]] : 1'b0; // R6

	// Match pulse shaping per channel
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			ch_ref_o <= 4'h0;
		else
			for (int c = 0; c < 4; c++) begin
				case (mpsel[c])
					tadc_pkg::MP_NORMAL: ch_ref_o[c] <= cmp_ref_i[c]; // R2
					tadc_pkg::MP_UP: // R3
						ch_ref_o[c] <= match_i[c] & ~count_down_i;
					tadc_pkg::MP_DOWN: // R4
						ch_ref_o[c] <= match_i[c] & count_down_i;
					default: ch_ref_o[c] <= match_i[c]; // R5
				endcase
			end
	end
	always_comb begin
		for (int c = 0; c < 4; c++)
			mpsel[c] = ctl2[tadc_pkg::POS_MPSEL + 2 * c +: 2];
	end

	// Jump detection: both quadrature inputs move in one cycle
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			jump_o <= 1'b0;
		else
			jump_o <= ctl2[tadc_pkg::POS_JUMP_EN] & a_chg & b_chg; // R1
	end

	// Supervision counters restart on each edge; idle while disabled
	logic disc_en, tmo;
	assign disc_en = ctl2[tadc_pkg::POS_DISC_EN];
	assign tmo = disc_en && (sup_a == period || sup_b == period); // R7 R8
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sup_a <= 32'h00000000;
			sup_b <= 32'h00000000;
		end else begin
			sup_a <= (!disc_en || a_chg || sup_a == period) ? 32'h00000000
				: sup_a + 32'h00000001; // R8
			sup_b <= (!disc_en || b_chg || sup_b == period) ? 32'h00000000
				: sup_b + 32'h00000001;
		end
	end
	// Sticky flag; a timeout in the clear cycle wins
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			disconnect_flag_o <= 1'b0;
		else if (tmo)
			disconnect_flag_o <= 1'b1; // R7
		else if (disconnect_clr_i)
			disconnect_flag_o <= 1'b0;
	end
	assign disconnect_irq_o = disconnect_flag_o & disconnect_irq_en_i;

	// Index reset qualification
	logic pos_ok, dir_ok, idx_hit;
	assign pos_ok = clk_dir_mode_i ? (pin[0] == idx_pos[0]) // R12
		: ({pin[1], pin[0]} == idx_pos); // R11
	always_comb begin
		case (idx_dir)
			tadc_pkg::DIR_BOTH: dir_ok = 1'b1; // R14
			tadc_pkg::DIR_UP: dir_ok = ~count_down_i;
			tadc_pkg::DIR_DOWN: dir_ok = count_down_i;
			default: dir_ok = 1'b0; // Reserved code never resets
		endcase
	end
	assign idx_hit = decctl[tadc_pkg::POS_IDXEN] && idx_rise && pos_ok &&
		dir_ok && !(decctl[tadc_pkg::POS_FIRST] && first_done); // R16 R13
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_reset_o <= 1'b0;
			first_done <= 1'b0;
		end else begin
			cnt_reset_o <= idx_hit;
			// Re-arming first-only needs the enable dropped
			if (!decctl[tadc_pkg::POS_IDXEN])
				first_done <= 1'b0;
			else if (idx_hit)
				first_done <= 1'b1; // R13
		end
	end

	// Decoder output pulse: width ticks of a 2**psc cycle clock
	logic tick;
	assign tick = pre_cnt == 7'((1 << psc) - 1); // R9
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pg_st <= tadc_pkg::PG_IDLE;
			pre_cnt <= 7'h00;
			wid_cnt <= 8'h00;
			dec_pulse_o <= 1'b0;
		end else begin
			case (pg_st)
				tadc_pkg::PG_IDLE: begin
					pre_cnt <= 7'h00;
					wid_cnt <= 8'h00;
					if (idx_hit && pwid != 8'h00) begin
						pg_st <= tadc_pkg::PG_RUN;
						dec_pulse_o <= 1'b1;
					end
				end
				tadc_pkg::PG_RUN: begin
					pre_cnt <= tick ? 7'h00 : pre_cnt + 7'h01;
					if (tick) begin
						wid_cnt <= wid_cnt + 8'h01;
						if (wid_cnt + 8'h01 == pwid) begin // R10
							pg_st <= tadc_pkg::PG_IDLE;
							dec_pulse_o <= 1'b0;
						end
					end
				end
				default: pg_st <= tadc_pkg::PG_IDLE;
			endcase
		end
	end

	// Checks
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	sequence up_match_s; match_i[0] && !count_down_i; endsequence
	sequence dn_match_s; match_i[0] && count_down_i; endsequence
	jump_detect_a: assert property (ctl2[18] && a_chg && b_chg |=> jump_o) // R1
		else $error("jump missed");
	normal_ref_a: assert property (mpsel[0] == 2'h0 |=> ch_ref_o[0] == // R2
		$past(cmp_ref_i[0])) else $error("normal ref wrong");
	pulse_up_a: assert property (mpsel[0] == 2'h1 ##0 dn_match_s // R3
		|=> !ch_ref_o[0]) else $error("up pulse on down");
	pulse_down_a: assert property (mpsel[0] == 2'h2 ##0 up_match_s // R4
		|=> !ch_ref_o[0]) else $error("down pulse on up");
	pulse_both_a: assert property (mpsel[0] == 2'h3 && match_i[0] && // R5
		!$past(match_i[0]) |=> ch_ref_o[0] ##1 !ch_ref_o[0] || $past(match_i[0]))
		else $error("pulse not one cycle");
	disc_flag_a: assert property (tmo |=> disconnect_flag_o) // R7
		else $error("timeout lost");
	disc_off_a: assert property (!disc_en |=> sup_a == 32'h0) // R8
		else $error("counter runs disabled");
	idx_enable_a: assert property (!decctl[0] |=> !cnt_reset_o) // R16
		else $error("index reset while disabled");
	first_only_a: assert property (decctl[5] && first_done |=> // R13
		!cnt_reset_o) else $error("second index reset");
	burst_wrap_a: assert property (is_win && xfer_cnt >= bcount |=> // R21
		xfer_cnt == 6'h0) else $error("count not wrapped");
	skip_equal_a: assert property (req_i.wr && cfg[1] && same // R20
		|-> !fwd_wr_o) else $error("equal write passed");
endmodule : tadc_top

// ==== tb/tadc_kernel_model.sv ====
// Behavioural timer kernel register file seen through the forward port
`timescale 1ns/1ps
module tadc_kernel_model (
	input wire logic clk_i,
	input wire logic [8:0] fwd_addr_i,
	input wire logic fwd_wr_i,
	input wire logic fwd_rd_i,
	input wire logic [31:0] fwd_wdata_i,
	output logic [31:0] fwd_rdata_o,
	output logic [3:0][31:0] cmp_val_o
);
	logic [31:0] mem [0:127]; // Kernel registers, word indexed
	logic [31:0] cur; // Word at the forwarded address
	// Clear the register file once at start
	initial begin
		for (int i = 0; i < 128; i++) begin
			mem[i] = 32'h00000000;
		end
	end
	// Writes land on the edge that takes the strobe
	always @(posedge clk_i) begin
		if (fwd_wr_i) begin
			mem[fwd_addr_i[8:2]] <= fwd_wdata_i;
		end
	end
	assign cur = mem[fwd_addr_i[8:2]];
	// Idle bus shows inverted data, so a stale value never passes as a read
	assign fwd_rdata_o = fwd_rd_i ? cur : ~cur;
	// Compare registers sit at word indices 13 to 16
	assign cmp_val_o = {mem[16], mem[15], mem[14], mem[13]};
endmodule : tadc_kernel_model

// ==== tb/timer_aux_decoder_dma_ctrl_test.sv ====
// Self-checking bench for the timer auxiliary control block
`timescale 1ns/1ps
module timer_aux_decoder_dma_ctrl_test;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	tadc_pkg::tadc_req_t req = '0; // Register request
	logic [31:0] rdata, fwd_wdata, fwd_rdata;
	logic rvalid, fwd_wr, fwd_rd, jump, dflag, dirq, crst, dpulse, rclr;
	logic [8:0] fwd_addr;
	logic [3:0][31:0] cmp_val;
	logic [3:0] match = 4'h0, cref = 4'h0, ch_ref;
	logic cdown = 1'b0, cdmode = 1'b0, ea = 1'b0, eb = 1'b0, eidx = 1'b0;
	logic irq_en = 1'b1, dclr = 1'b0;
	logic [7:0] cmp_out = 8'h00;
	int bad_count = 0, n_tests = 0, cyc = 0, wcnt = 0;
	logic [31:0] got;
	always #10 clk_i = ~clk_i;
	tadc_top dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req),
		.rdata_o(rdata), .rvalid_o(rvalid), .fwd_addr_o(fwd_addr),
		.fwd_wr_o(fwd_wr), .fwd_rd_o(fwd_rd), .fwd_wdata_o(fwd_wdata),
		.fwd_rdata_i(fwd_rdata), .cmp_val_i(cmp_val), .match_i(match),
		.cmp_ref_i(cref), .count_down_i(cdown), .clk_dir_mode_i(cdmode),
		.cmp_out_i(cmp_out), .enc_a_i(ea), .enc_b_i(eb), .enc_idx_i(eidx),
		.disconnect_irq_en_i(irq_en), .disconnect_clr_i(dclr),
		.ch_ref_o(ch_ref), .ref_clear_o(rclr), .jump_o(jump),
		.disconnect_flag_o(dflag), .disconnect_irq_o(dirq),
		.cnt_reset_o(crst), .dec_pulse_o(dpulse));
	tadc_kernel_model mdl_u (.clk_i(clk_i), .fwd_addr_i(fwd_addr),
		.fwd_wr_i(fwd_wr), .fwd_rd_i(fwd_rd), .fwd_wdata_i(fwd_wdata),
		.fwd_rdata_o(fwd_rdata), .cmp_val_o(cmp_val));
	// Count forwarded writes to the channel 0 compare register
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (fwd_wr === 1'b1 && fwd_addr === 9'h034) begin
			wcnt <= wcnt + 1;
		end
		if (cyc == 20000) begin
			bad_count = bad_count + 1;
			finish_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_tests = n_tests + 1;
		if (g !== e) begin
			bad_count = bad_count + 1;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// One-cycle write, launched on the falling edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge clk_i);
		req.wr = 1'b1;
		req.addr = a;
		req.wdata = d;
		@(negedge clk_i);
		req.wr = 1'b0;
	endtask : wr
	// Read: data is valid one cycle after the request
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(negedge clk_i);
		req.rd = 1'b1;
		req.addr = a;
		@(negedge clk_i);
		req.rd = 1'b0;
		chk("rvalid", 32'h1, {31'h0, rvalid});
		d = rdata;
	endtask : rd
	// Count output high cycles over a window while pins settle
	task automatic watch(input int n, output int nj, output int nr,
		output int np);
		nj = 0;
		nr = 0;
		np = 0;
		repeat (n) begin
			@(negedge clk_i);
			if (nr + np == 0 && eidx) begin
				eidx = 1'b0;
			end
			nj = nj + int'(jump === 1'b1);
			nr = nr + int'(crst === 1'b1);
			np = np + int'(dpulse === 1'b1);
		end
	endtask : watch
	task automatic idx_try(input logic ab, input int er, input int ep);
		int nj, nr, np;
		ea = ab;
		eb = ab;
		repeat (10) @(negedge clk_i);
		eidx = 1'b1;
		repeat (3) @(negedge clk_i);
		eidx = 1'b0;
		watch(30, nj, nr, np);
		chk("cnt_reset", er, nr);
		chk("pulse_len", ep, np);
	endtask : idx_try
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : finish_test
	logic [7:0] ra [5] = '{8'h90, 8'h94, 8'hA0, 8'hE0, 8'hFC};
	int nj, nr, np;
	logic e;
	initial begin
		repeat (12) @(negedge clk_i);
		rst_b_i = 1'b1;
		// Reset values of the mapped registers except ctl2
		foreach (ra[i]) begin
			rd(ra[i], got);
			chk("reset", (ra[i] == 8'h94) ? 32'hFFFFFFFF : 32'h0, got);
		end
		$display("test reset done");
		// Match pulse codes in both counting directions
		// Same code on all four channels, so every field position is seen
		cref = 4'hF;
		for (int c = 0; c < 4; c++) begin
			for (int d = 0; d < 2; d++) begin
				wr(8'h74, 32'(c) * 32'h00005500);
				cdown = d[0];
				match = 4'hF;
				@(negedge clk_i);
				match = 4'h0;
				e = (c == 0) || (c == 3) || (c == 1 && d == 0) || (c == 2 && d == 1);
				chk("ch_ref", {28'h0, {4{e}}}, {28'h0, ch_ref});
				@(negedge clk_i);
				chk("ch_ref_end", {28'h0, {4{c == 0}}}, {28'h0, ch_ref});
			end
		end
		$display("test match done");
		// Clear input select over all eight sources
		wr(8'h90, 32'hFFFFFFFF);
		rd(8'h90, got);
		chk("afctl1", 32'h00380000, got);
		for (int s = 0; s < 8; s++) begin
			wr(8'h90, 32'(s) << 19);
			cmp_out = 8'h01 << s;
			repeat (6) @(negedge clk_i);
			chk("clear_sel", 32'h1, {31'h0, rclr});
			cmp_out = ~(8'h01 << s);
			repeat (6) @(negedge clk_i);
			chk("clear_off", 32'h0, {31'h0, rclr});
		end
		$display("test clear done");
		// Burst of three from compare 0, a fourth write wraps
		wr(8'hE0, 32'h0000020D);
		wr(8'hE4, 32'h11);
		wr(8'hE4, 32'h22);
		wr(8'hE4, 32'h33);
		wr(8'hE4, 32'h44);
		rd(8'h34, got);
		chk("burst_w0", 32'h44, got);
		rd(8'h38, got);
		chk("burst_w1", 32'h22, got);
		rd(8'h3C, got);
		chk("burst_w2", 32'h33, got);
		rd(8'hE4, got);
		chk("burst_r0", 32'h22, got);
		rd(8'hE4, got);
		chk("burst_r1", 32'h33, got);
		$display("test burst done");
		// Equal compare writes are dropped only when skipping is on
		wr(8'hE0, 32'h0);
		wr(8'h34, 32'h44);
		// Two burst writes already reached compare 0
		chk("no_skip", 32'h3, 32'(wcnt));
		wr(8'hFC, 32'h2);
		wr(8'h34, 32'h44);
		chk("skip_eq", 32'h3, 32'(wcnt));
		wr(8'h34, 32'h55);
		chk("skip_ne", 32'h4, 32'(wcnt));
		$display("test skip done");
		// Index at 11, width 3, prescale 1: pulse of six cycles
		wr(8'hA0, 32'h010300C1);
		idx_try(1'b1, 1, 6);
		idx_try(1'b0, 0, 0);
		// Direction only changes with index reset disabled
		wr(8'hA0, 32'h010300C0);
		wr(8'hA0, 32'h010300C2);
		cdown = 1'b1;
		wr(8'hA0, 32'h010300C3);
		idx_try(1'b1, 0, 0);
		cdown = 1'b0;
		idx_try(1'b1, 1, 6);
		wr(8'hA0, 32'h010300C2);
		idx_try(1'b1, 0, 0);
		wr(8'hA0, 32'h010300C0);
		wr(8'hA0, 32'h010300E1);
		idx_try(1'b1, 1, 6);
		idx_try(1'b1, 0, 0);
		// Clock/direction mode: position 01 needs only A high
		cdmode = 1'b1;
		wr(8'hA0, 32'h01030041);
		idx_try(1'b0, 0, 0);
		idx_try(1'b1, 1, 6);
		cdmode = 1'b0;
		$display("test index done");
		// Simultaneous change of both decoder inputs
		wr(8'hA0, 32'h0);
		wr(8'h74, 32'h00040000);
		ea = 1'b0;
		eb = 1'b0;
		watch(12, nj, nr, np);
		chk("jump_on", 32'd1, 32'(nj));
		wr(8'h74, 32'h0);
		ea = 1'b1;
		eb = 1'b1;
		watch(12, nj, nr, np);
		chk("jump_off", 32'd0, 32'(nj));
		$display("test jump done");
		// Supervision period only counts with detection enabled
		wr(8'h94, 32'h00000014);
		repeat (60) @(negedge clk_i);
		chk("disc_off", 32'h0, {31'h0, dflag});
		wr(8'h74, 32'h00080000);
		repeat (60) @(negedge clk_i);
		chk("disc_flag", 32'h1, {31'h0, dflag});
		chk("disc_irq", 32'h1, {31'h0, dirq});
		irq_en = 1'b0;
		@(negedge clk_i);
		chk("disc_irq_off", 32'h0, {31'h0, dirq});
		irq_en = 1'b1;
		wr(8'h74, 32'h0);
		dclr = 1'b1;
		@(negedge clk_i);
		dclr = 1'b0;
		@(negedge clk_i);
		chk("disc_clr", 32'h0, {31'h0, dflag});
		$display("test supervision done");
		finish_test();
	end
endmodule : timer_aux_decoder_dma_ctrl_test
